// ===== rtl/eba_pkg.sv
// Function
// - Byte-wide store of 512, 1K or 2K bytes
// - Read stalls the processor four cycles
// - Write launch stalls the processor two cycles
// - Arm by master enable with strobe zero
// - Strobe must follow arming within four cycles
// - Master enable times out; late strobe ignored
// - Hardware clears write strobe when write done
// - Write timed from calibrated RC oscillator
// - Write lasts 27072 RC oscillator cycles
// - No reads or address changes while writing
// - No write while flash self-programming busy
// - Wait for strobe zero before arming
// - Address and data loads in any order
// - Poll strobe zero before a read
// - Keep interrupts off during the sequence
// - Read strobe loads addressed byte into data
// - Linear addressing from zero upward
// - Reset during a write lets it finish
package eba_pkg;
	// ----------------------------------------
	// Store and timing
	// ----------------------------------------
	localparam int         NV_BYTES_DEF        = 512;
	localparam int         WRITE_RC_CYCLES_DEF = 27072;
	localparam int         RC_CNT_W            = 16;
	localparam logic [2:0] MWE_WINDOW          = 3'h4;
	localparam logic [2:0] READ_STALL          = 3'h4;
	localparam logic [2:0] WRITE_STALL         = 3'h2;
	// ----------------------------------------
	// Processor-side register selects and bits
	// ----------------------------------------
	localparam logic [1:0] IO_CTRL    = 2'h0;
	localparam logic [1:0] IO_DATA    = 2'h1;
	localparam logic [1:0] IO_ADDR_LO = 2'h2;
	localparam logic [1:0] IO_ADDR_HI = 2'h3;
	localparam int         CTL_RD     = 0;
	localparam int         CTL_WR     = 1;
	localparam int         CTL_MWE    = 2;
	// ----------------------------------------
	// APB map of the controller
	// ----------------------------------------
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;
	localparam int         CMD_WRITE  = 0;
	localparam int         CMD_READ   = 1;
	localparam int         CMD_FLASH  = 2;
	localparam int         ST_BUSY    = 0;
	localparam int         ST_FLASH   = 1;
endpackage

// ===== rtl/eba_if.sv
`timescale 1ns/100ps
interface eba_if;
	logic [1:0] io_sel;
	logic       io_we;
	logic       io_re;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       cpu_stall;
	logic       self_program_busy;
	modport dev (
		input  io_sel,
		input  io_we,
		input  io_re,
		input  io_wdata,
		input  self_program_busy,
		output io_rdata,
		output cpu_stall
	);
	modport cpu (
		output io_sel,
		output io_we,
		output io_re,
		output io_wdata,
		output self_program_busy,
		input  io_rdata,
		input  cpu_stall
	);
endinterface

// ===== rtl/eba_nv_dev.sv
`timescale 1ns/100ps
module eba_nv_dev
	import eba_pkg::*;
#(
	parameter int NV_BYTES        = NV_BYTES_DEF,
	parameter int WRITE_RC_CYCLES = WRITE_RC_CYCLES_DEF
) (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic por_n,
	input  wire logic rc_osc,
	output logic      write_active,
	eba_if.dev        bus
);
	localparam int AW = $clog2(NV_BYTES);

	initial begin
		if (NV_BYTES != 512 && NV_BYTES != 1024 && NV_BYTES != 2048)
			$error("NV_BYTES must be 512, 1024 or 2048");
		if (WRITE_RC_CYCLES < 1 || WRITE_RC_CYCLES >= (1 << RC_CNT_W))
			$error("WRITE_RC_CYCLES out of range");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Processor-visible registers, cleared by the ordinary reset
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [7:0]    data;
		logic [2:0]    mwe_cnt;
		logic [2:0]    stall_cnt;
		logic [7:0]    rdata;
	} eba_core_t;

	// Write engine and store, cleared only at power-on so that an ordinary
	// reset in mid-write does not abort the programming
	typedef struct packed {
		logic [1:0]                rc_sync;
		logic                      rc_prev;
		logic                      busy;
		logic [RC_CNT_W-1:0]       rc_cnt;
		logic [AW-1:0]             waddr;
		logic [7:0]                wdata;
		logic [NV_BYTES-1:0][7:0]  mem;
	} eba_eng_t;

	eba_core_t c, next_c;
	eba_eng_t  e, next_e;
	logic      launch;
	logic      rc_edge;

	function automatic logic [AW-1:0] put_byte(logic [AW-1:0] a, logic hi, logic [7:0] b);
		logic [15:0] w;
		w = 16'(a);
		if (hi)
			w[15:8] = b;
		else
			w[7:0] = b;
		return w[AW-1:0];
	endfunction

	// ----------------------------------------
	// Processor interface
	// ----------------------------------------
	always_comb begin
		logic        take;
		logic [15:0] a16;
		take   = 1'b0;
		a16    = 16'(c.addr);
		next_c = c;
		launch = 1'b0;
		if (c.stall_cnt != 3'h0)
			next_c.stall_cnt = c.stall_cnt - 3'h1;
		if (c.mwe_cnt != 3'h0)
			next_c.mwe_cnt = c.mwe_cnt - 3'h1;
		// Writes during a stall are dropped: the processor is halted then
		take = bus.io_we && (c.stall_cnt == 3'h0);
		if (take) begin
			case (bus.io_sel)
				IO_CTRL: begin
					if (bus.io_wdata[CTL_MWE] && !bus.io_wdata[CTL_WR]) begin
						next_c.mwe_cnt = MWE_WINDOW;
					end else if (bus.io_wdata[CTL_WR]) begin
						// Strobe alone, late, or during flash work does nothing
						if (c.mwe_cnt != 3'h0 && !e.busy && !bus.self_program_busy) begin
							launch            = 1'b1;
							next_c.mwe_cnt    = 3'h0;
							next_c.stall_cnt  = WRITE_STALL;
						end
					end else if (bus.io_wdata[CTL_RD] && !e.busy) begin
						next_c.data      = e.mem[c.addr];
						next_c.stall_cnt = READ_STALL;
					end
				end
				IO_DATA: begin
					next_c.data = bus.io_wdata;
				end
				IO_ADDR_LO: begin
					if (!e.busy)
						next_c.addr = put_byte(c.addr, 1'b0, bus.io_wdata);
				end
				IO_ADDR_HI: begin
					if (!e.busy)
						next_c.addr = put_byte(c.addr, 1'b1, bus.io_wdata);
				end
				default: begin
					next_c.data = c.data;
				end
			endcase
		end
		if (bus.io_re) begin
			case (bus.io_sel)
				IO_CTRL: begin
					next_c.rdata          = 8'h00;
					next_c.rdata[CTL_WR]  = e.busy;
					next_c.rdata[CTL_MWE] = (c.mwe_cnt != 3'h0);
				end
				IO_DATA:    next_c.rdata = c.data;
				IO_ADDR_LO: next_c.rdata = a16[7:0];
				IO_ADDR_HI: next_c.rdata = a16[15:8];
				default:    next_c.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			c <= '0;
		else
			c <= next_c;
	end

	// ----------------------------------------
	// Self-timed write engine
	// ----------------------------------------
	// The oscillator must run below half of ref_clk to be counted
	assign rc_edge = e.rc_sync[1] && !e.rc_prev;

	always_comb begin
		next_e         = e;
		next_e.rc_sync = {e.rc_sync[0], rc_osc};
		next_e.rc_prev = e.rc_sync[1];
		if (launch) begin
			next_e.busy   = 1'b1;
			next_e.waddr  = c.addr;
			next_e.wdata  = c.data;
			next_e.rc_cnt = RC_CNT_W'(WRITE_RC_CYCLES);
		end else if (e.busy && rc_edge) begin
			next_e.rc_cnt = e.rc_cnt - 1'b1;
			if (e.rc_cnt == RC_CNT_W'(1)) begin
				next_e.mem[e.waddr] = e.wdata;
				next_e.busy         = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n)
			e <= '0;
		else
			e <= next_e;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus.cpu_stall = (c.stall_cnt != 3'h0);
	assign bus.io_rdata  = c.rdata;
	assign write_active  = e.busy;
endmodule

// ===== rtl/eba_nv_cpu.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/100ps
module eba_nv_cpu
	import eba_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	eba_if.cpu               bus
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [10:0] {
		S_IDLE  = 11'b000_0000_0001,
		S_POLL  = 11'b000_0000_0010,
		S_CHK   = 11'b000_0000_0100,
		S_LDA_L = 11'b000_0000_1000,
		S_LDA_H = 11'b000_0001_0000,
		S_LDD   = 11'b000_0010_0000,
		S_ARM   = 11'b000_0100_0000,
		S_FIRE  = 11'b000_1000_0000,
		S_RSTB  = 11'b001_0000_0000,
		S_RGET  = 11'b010_0000_0000,
		S_RTAKE = 11'b100_0000_0000
	} eba_state_t;

	typedef struct packed {
		eba_state_t  state;
		logic        is_read;
		logic        flash;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  rdata;
		logic        gap;
		logic [1:0]  io_sel;
		logic        io_we;
		logic        io_re;
		logic [7:0]  io_wdata;
		logic [31:0] prdata;
	} eba_cpu_t;

	eba_cpu_t c, next_c;

	function automatic logic mapped(logic [7:0] a);
		return a == REG_CMD || a == REG_ADDR || a == REG_WDATA ||
			a == REG_STATUS || a == REG_RDATA;
	endfunction

	// ----------------------------------------
	// APB slave and access sequencer
	// ----------------------------------------
	always_comb begin
		logic adv;
		logic wr;
		adv    = !c.gap && !bus.cpu_stall;
		wr     = psel && penable && pwrite;
		next_c = c;
		next_c.io_we = 1'b0;
		next_c.io_re = 1'b0;
		if (psel && !penable) begin
			next_c.prdata = 32'h0000_0000;
			case (paddr)
				REG_CMD:    next_c.prdata[CMD_FLASH] = c.flash;
				REG_ADDR:   next_c.prdata[15:0] = c.addr;
				REG_WDATA:  next_c.prdata[7:0] = c.wdata;
				REG_STATUS: begin
					next_c.prdata[ST_BUSY]  = (c.state != S_IDLE);
					next_c.prdata[ST_FLASH] = c.flash;
				end
				REG_RDATA:  next_c.prdata[7:0] = c.rdata;
				default:    next_c.prdata = 32'h0000_0000;
			endcase
		end
		// Operands are frozen while a sequence runs so the byte stays intact
		if (wr && c.state == S_IDLE) begin
			case (paddr)
				REG_ADDR:  next_c.addr = pwdata[15:0];
				REG_WDATA: next_c.wdata = pwdata[7:0];
				REG_CMD: begin
					next_c.is_read = pwdata[CMD_READ];
					if (pwdata[CMD_WRITE] || pwdata[CMD_READ])
						next_c.state = S_POLL;
				end
				default: next_c.addr = c.addr;
			endcase
		end
		if (wr && paddr == REG_CMD)
			next_c.flash = pwdata[CMD_FLASH];
		case (c.state)
			S_IDLE: begin
				next_c.gap = 1'b0;
			end
			S_POLL: if (adv) begin
				next_c.io_sel = IO_CTRL;
				next_c.io_re  = 1'b1;
				next_c.state  = S_CHK;
			end
			S_CHK: if (adv) begin
				// A single sequencer never re-enters mid-sequence, so no
				// handler can disturb the arming window
				if (bus.io_rdata[CTL_WR] || c.flash)
					next_c.state = S_POLL;
				else
					next_c.state = S_LDA_L;
			end
			S_LDA_L: if (adv) begin
				next_c.io_sel   = IO_ADDR_LO;
				next_c.io_wdata = c.addr[7:0];
				next_c.io_we    = 1'b1;
				next_c.state    = S_LDA_H;
			end
			S_LDA_H: if (adv) begin
				next_c.io_sel   = IO_ADDR_HI;
				next_c.io_wdata = c.addr[15:8];
				next_c.io_we    = 1'b1;
				next_c.state    = c.is_read ? S_RSTB : S_LDD;
			end
			S_LDD: if (adv) begin
				next_c.io_sel   = IO_DATA;
				next_c.io_wdata = c.wdata;
				next_c.io_we    = 1'b1;
				next_c.state    = S_ARM;
			end
			S_ARM: if (adv) begin
				next_c.io_sel   = IO_CTRL;
				next_c.io_wdata = 8'h00;
				next_c.io_wdata[CTL_MWE] = 1'b1;
				next_c.io_we    = 1'b1;
				next_c.state    = S_FIRE;
			end
			S_FIRE: if (adv) begin
				next_c.io_sel   = IO_CTRL;
				next_c.io_wdata = 8'h00;
				next_c.io_wdata[CTL_WR] = 1'b1;
				next_c.io_we    = 1'b1;
				next_c.state    = S_IDLE;
			end
			S_RSTB: if (adv) begin
				next_c.io_sel   = IO_CTRL;
				next_c.io_wdata = 8'h00;
				next_c.io_wdata[CTL_RD] = 1'b1;
				next_c.io_we    = 1'b1;
				next_c.state    = S_RGET;
			end
			S_RGET: if (adv) begin
				next_c.io_sel = IO_DATA;
				next_c.io_re  = 1'b1;
				next_c.state  = S_RTAKE;
			end
			S_RTAKE: if (adv) begin
				next_c.rdata = bus.io_rdata;
				next_c.state = S_IDLE;
			end
			default: next_c.state = S_IDLE;
		endcase
		// One idle cycle after each access lets a stall become visible
		next_c.gap = next_c.io_we || next_c.io_re;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			c       <= '0;
			c.state <= S_IDLE;
		end else begin
			c <= next_c;
		end
	end

	assign prdata                = c.prdata;
	assign pready                = 1'b1;
	assign pslverr               = psel && penable && !mapped(paddr);
	assign bus.io_sel            = c.io_sel;
	assign bus.io_we             = c.io_we;
	assign bus.io_re             = c.io_re;
	assign bus.io_wdata          = c.io_wdata;
	assign bus.self_program_busy = c.flash;
endmodule

// ===== testbench/eba_checker.sv
`timescale 1ns/100ps
module eba_checker
	import eba_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic [1:0] io_sel,
	input wire logic       io_we,
	input wire logic       io_re,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       cpu_stall,
	input wire logic       self_program_busy,
	input wire logic       write_active
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [3:0] since_arm;
	logic [3:0] stall_run;
	logic       ctl_wr;
	assign ctl_wr = io_we && io_sel == IO_CTRL;
	// Saturates so a stale arm can never look fresh
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			since_arm <= 4'hF;
			stall_run <= 4'h0;
		end else begin
			if (ctl_wr && io_wdata == 8'h04)
				since_arm <= 4'h0;
			else if (since_arm != 4'hF)
				since_arm <= since_arm + 4'h1;
			stall_run <= cpu_stall ? stall_run + 4'h1 : 4'h0;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_rd_stall;
		ctl_wr && io_wdata == 8'h01 && !cpu_stall && !write_active
			|=> cpu_stall [*4] ##1 !cpu_stall;
	endproperty
	a_rd_stall: assert property (p_rd_stall) else $error("read stall wrong");
	property p_wr_stall;
		$rose(write_active) |-> cpu_stall [*2] ##1 !cpu_stall;
	endproperty
	a_wr_stall: assert property (p_wr_stall) else $error("write stall wrong");
	property p_wr_cause;
		$rose(write_active) |-> $past(ctl_wr && io_wdata == 8'h02 && !self_program_busy);
	endproperty
	a_wr_cause: assert property (p_wr_cause) else $error("bad launch");
	property p_arm_win;
		$rose(write_active) |-> since_arm inside {[1:4]};
	endproperty
	a_arm_win: assert property (p_arm_win) else $error("launch out of window");
	property p_rd_busy;
		write_active && ctl_wr && io_wdata == 8'h01 && !cpu_stall |=> !cpu_stall;
	endproperty
	a_rd_busy: assert property (p_rd_busy) else $error("read while writing");
	property p_rdata_hold;
		!io_re |=> $stable(io_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_stall_max;
		stall_run <= 4'h4;
	endproperty
	a_stall_max: assert property (p_stall_max) else $error("stall too long");
	property p_busy_hold;
		$rose(write_active) |-> write_active [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("write too short");
	c_read: cover property (ctl_wr && io_wdata == 8'h01);
	c_launch: cover property ($rose(write_active));
	c_flash: cover property (self_program_busy && ctl_wr);
endmodule

// ===== testbench/test_eeprom_byte_access_ctrl.sv
`timescale 1ns/100ps
module test_eeprom_byte_access_ctrl
	import eba_pkg::*;
;
	// ----------------------------------------
	// Bench
	// ----------------------------------------
	// Short write keeps the run small; checks derive from it
	localparam int WRC = 4;
	logic        ref_clk = 1'b0;
	logic        rstn    = 1'b0;
	logic        por_n   = 1'b0;
	logic        rc_osc  = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        se;
	logic        write_active;
	logic [2:0]  rc_div  = 3'h0;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          rc_n = 0;
	eba_if eba_if_i ();
	eba_nv_dev #(.NV_BYTES(512), .WRITE_RC_CYCLES(WRC)) eba_nv_dev_i (.ref_clk(ref_clk),
		.rstn(rstn), .por_n(por_n), .rc_osc(rc_osc), .write_active(write_active),
		.bus(eba_if_i));
	eba_nv_cpu eba_nv_cpu_i (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(eba_if_i));
	eba_checker eba_checker_i (.ref_clk(ref_clk), .rstn(rstn), .io_sel(eba_if_i.io_sel),
		.io_we(eba_if_i.io_we), .io_re(eba_if_i.io_re), .io_wdata(eba_if_i.io_wdata),
		.io_rdata(eba_if_i.io_rdata), .cpu_stall(eba_if_i.cpu_stall),
		.self_program_busy(eba_if_i.self_program_busy), .write_active(write_active));
	always #10 ref_clk = ~ref_clk;
	// Oscillator kept well below half the bus clock
	always @(posedge ref_clk) begin
		rc_div <= (rc_div == 3'h4) ? 3'h0 : rc_div + 3'h1;
		if (rc_div == 3'h4)
			rc_osc <= ~rc_osc;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			final_report;
		end
	end
	always @(posedge rc_osc) if (write_active) rc_n++;
	task final_report;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task poll;
		int k;
		k = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			k++;
		end while (rd[ST_BUSY] !== 1'b0 && k < 400);
		chk({31'h0, rd[ST_BUSY]}, 32'h0);
	endtask
	task nv_wr(input logic [15:0] a, input logic [7:0] d);
		apb(1'b1, REG_ADDR, {16'h0, a});
		apb(1'b1, REG_WDATA, {24'h0, d});
		apb(1'b1, REG_CMD, 32'h1 << CMD_WRITE);
		poll;
	endtask
	task nv_rd(input logic [15:0] a);
		apb(1'b1, REG_ADDR, {16'h0, a});
		apb(1'b1, REG_CMD, 32'h1 << CMD_READ);
		poll;
		apb(1'b0, REG_RDATA, 32'h0);
	endtask
	task t_rw;
		nv_wr(16'h0000, 8'hA5);
		nv_wr(16'h01FF, 8'h5A);
		nv_rd(16'h0000);
		chk(rd, 32'hA5);
		nv_rd(16'h01FF);
		chk(rd, 32'h5A);
		$display("t_rw done");
	endtask
	task t_len;
		int k;
		rc_n = 0;
		nv_wr(16'h0003, 8'hC3);
		// The sequencer idles right after launch, so wait out the write itself
		k = 0;
		while (write_active !== 1'b0 && k < 400) begin
			@(posedge ref_clk);
			k++;
		end
		chk({31'h0, write_active}, 32'h0);
		// Synchroniser lag lets the first counted edge fall just before launch
		chk({31'h0, rc_n inside {WRC - 1, WRC}}, 32'h1);
		nv_rd(16'h0003);
		chk(rd, 32'hC3);
		$display("t_len done");
	endtask
	task t_flash;
		apb(1'b1, REG_WDATA, 32'h3C);
		apb(1'b1, REG_CMD, (32'h1 << CMD_FLASH) | (32'h1 << CMD_WRITE));
		apb(1'b0, REG_STATUS, 32'h0);
		chk({31'h0, rd[ST_FLASH]}, 32'h1);
		repeat (60) @(posedge ref_clk);
		chk({31'h0, write_active}, 32'h0);
		apb(1'b1, REG_CMD, 32'h0);
		poll;
		$display("t_flash done");
	endtask
	task t_rst;
		int k;
		// A write still running from before would be mistaken for this one
		k = 0;
		while (write_active !== 1'b0 && k < 400) begin
			@(posedge ref_clk);
			k++;
		end
		apb(1'b1, REG_ADDR, 32'h7);
		apb(1'b1, REG_WDATA, 32'h96);
		apb(1'b1, REG_CMD, 32'h1 << CMD_WRITE);
		k = 0;
		while (write_active !== 1'b1 && k < 100) begin
			@(posedge ref_clk);
			k++;
		end
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		chk({31'h0, write_active}, 32'h1);
		poll;
		nv_rd(16'h0007);
		chk(rd, 32'h96);
		$display("t_rst done");
	endtask
	task t_unmap;
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		chk({31'h0, se}, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		$display("t_unmap done");
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		por_n <= 1'b1;
		@(posedge ref_clk);
		t_rw;
		t_len;
		t_flash;
		t_rst;
		t_unmap;
		final_report;
	end
endmodule
